// [logic/ipp_core.v]
/*
 * Interrupt status, priority and proximity block, top level.
 * Holds the Wishbone register file, selects the winning source, defers
 * low-priority interrupts through the proximity timer and presents the
 * result to the processor core.
 * Assumes a classic Wishbone master on the same clock and level-held
 * interrupt requests from the sources.
 */
`timescale 1ns/1ps
`include "ipp_regs.vh"
module ipp_core (
	// Clock, reset and enable
	input wire i_core_clk,
	input wire i_resetn,
	input wire i_ce,
	// Wishbone slave
	input wire i_wb_cyc,
	input wire i_wb_stb,
	input wire i_wb_we,
	input wire [4:0] i_wb_adr,
	input wire [3:0] i_wb_sel,
	input wire [31:0] i_wb_dat,
	output reg [31:0] o_wb_dat,
	output reg o_wb_ack,
	output reg o_wb_err,
	// Interrupt sources
	input wire [1:0] i_src_req,
	// Processor core side
	output reg o_core_irq_req,
	output reg [2:0] o_core_irq_level,
	output reg [5:0] o_core_irq_vector,
	output wire o_prox_expired
);

	////////////////////////////////////////////////////////////////////////
	// Register storage

	reg [31:0] reload;
	reg [31:0] prioctl;
	reg [31:0] ctrl;
	reg [2:0] presented_priority_level;
	reg [5:0] presented_isr_index;

	wire [31:0] tmr_count;
	wire tmr_running;
	wire tmr_expired;

	// Decodes a word offset into a one-hot register select
	function [5:0] ipp_decode;
		input [4:0] adr;
		begin
			case ({adr[4:2], 2'b00})
				`IPP_OFS_STATUS: ipp_decode = 6'h01;
				`IPP_OFS_RELOAD: ipp_decode = 6'h02;
				`IPP_OFS_PRIOCTL: ipp_decode = 6'h04;
				`IPP_OFS_CTRL: ipp_decode = 6'h08;
				`IPP_OFS_TMRCNT: ipp_decode = 6'h10;
				`IPP_OFS_TMRSTAT: ipp_decode = 6'h20;
				default: ipp_decode = 6'h00;
			endcase
		end
	endfunction

	////////////////////////////////////////////////////////////////////////
	// Wishbone access

	wire wb_req = i_wb_cyc & i_wb_stb & ~o_wb_ack & ~o_wb_err;
	wire [5:0] wb_hit = ipp_decode(i_wb_adr);
	wire wb_wr = wb_req & i_wb_we & i_ce;
	wire [31:0] lane_mask;

	genvar gl;
	generate
		for (gl = 0; gl < 4; gl = gl + 1) begin : g_lane
			assign lane_mask[gl*8 +: 8] = {8{i_wb_sel[gl]}};
		end
	endgenerate

	// Read view of each register
	reg [31:0] rd_data;
	always @* begin
		rd_data = 32'h00000000;
		case (1'b1)
			wb_hit[0]: begin
				rd_data[`IPP_STAT_LVL_MSB:`IPP_STAT_LVL_LSB] = presented_priority_level;
				rd_data[`IPP_STAT_VEC_MSB:`IPP_STAT_VEC_LSB] = presented_isr_index;
			end
			wb_hit[1]: rd_data = reload;
			wb_hit[2]: rd_data = prioctl & `IPP_PC_WMASK;
			wb_hit[3]: rd_data = ctrl & `IPP_CTRL_WMASK;
			wb_hit[4]: rd_data = tmr_count;
			wb_hit[5]: begin
				rd_data[`IPP_TS_RUN_BIT] = tmr_running;
				rd_data[`IPP_TS_EXP_BIT] = tmr_expired;
			end
			default: rd_data = 32'h00000000;
		endcase
	end

	// Ack or err one enabled cycle after the request; both drop the next enabled cycle
	always @(posedge i_core_clk or negedge i_resetn) begin
		if (!i_resetn) begin
			o_wb_ack <= 1'b0;
			o_wb_err <= 1'b0;
			o_wb_dat <= 32'h00000000;
		end else if (i_ce) begin
			o_wb_ack <= wb_req & (wb_hit != 6'h00);
			o_wb_err <= wb_req & (wb_hit == 6'h00);
			if (wb_req && !i_wb_we) begin
				o_wb_dat <= rd_data;
			end
		end
	end

	// Writes take effect at the request edge; status words ignore writes
	always @(posedge i_core_clk or negedge i_resetn) begin
		if (!i_resetn) begin
			reload <= `IPP_RST_RELOAD;
			prioctl <= `IPP_RST_PRIOCTL;
			ctrl <= `IPP_RST_CTRL;
		end else if (wb_wr) begin
			if (wb_hit[1]) begin
				reload <= (reload & ~lane_mask) | (i_wb_dat & lane_mask);
			end
			if (wb_hit[2]) begin
				prioctl <= ((prioctl & ~lane_mask) | (i_wb_dat & lane_mask)) & `IPP_PC_WMASK;
			end
			if (wb_hit[3]) begin
				ctrl <= ((ctrl & ~lane_mask) | (i_wb_dat & lane_mask)) & `IPP_CTRL_WMASK;
			end
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Source selection

	wire arb_valid;
	wire arb_sel_b;
	wire [2:0] arb_level;

	ipp_arbiter u_arbiter (
		.i_req(i_src_req),
		.i_pri_a(prioctl[`IPP_PC_A_PRI_MSB:`IPP_PC_A_PRI_LSB]),
		.i_sub_a(prioctl[`IPP_PC_A_SUB_MSB:`IPP_PC_A_SUB_LSB]),
		.i_pri_b(prioctl[`IPP_PC_B_PRI_MSB:`IPP_PC_B_PRI_LSB]),
		.i_sub_b(prioctl[`IPP_PC_B_SUB_MSB:`IPP_PC_B_SUB_LSB]),
		.o_valid(arb_valid),
		.o_sel_b(arb_sel_b),
		.o_level(arb_level)
	);

	////////////////////////////////////////////////////////////////////////
	// Proximity deferral

	wire [2:0] threshold = ctrl[`IPP_CTRL_THR_MSB:`IPP_CTRL_THR_LSB];
	// Threshold zero disables deferral since no enabled level is at or below it
	wire deferrable = arb_valid & (arb_level <= threshold);
	wire forward = arb_valid & (~deferrable | tmr_expired);

	ipp_prox_timer u_prox_timer (
		.i_core_clk(i_core_clk),
		.i_resetn(i_resetn),
		.i_ce(i_ce),
		.i_trigger(deferrable),
		.i_reload(reload),
		.o_count(tmr_count),
		.o_running(tmr_running),
		.o_expired(tmr_expired)
	);

	assign o_prox_expired = tmr_expired;

	////////////////////////////////////////////////////////////////////////
	// Presentation to the core

	wire [5:0] next_vector = arb_sel_b ? `IPP_VEC_SRC_B : `IPP_VEC_SRC_A;

	// Status keeps the last forwarded values after the request goes away
	always @(posedge i_core_clk or negedge i_resetn) begin
		if (!i_resetn) begin
			o_core_irq_req <= 1'b0;
			o_core_irq_level <= 3'h0;
			o_core_irq_vector <= 6'h00;
			presented_priority_level <= 3'h0;
			presented_isr_index <= 6'h00;
		end else if (i_ce) begin
			o_core_irq_req <= forward;
			if (forward) begin
				o_core_irq_level <= arb_level;
				o_core_irq_vector <= next_vector;
				presented_priority_level <= arb_level;
				presented_isr_index <= next_vector;
			end
		end
	end

endmodule

// [shared/ipp_regs.vh]
/*
 * Register offsets, field positions, reset values and fixed codes of the
 * interrupt status, priority and proximity timer block.
 * Assumes a 32-bit classic Wishbone slave port with byte addresses.
 */
`ifndef IPP_REGS_VH
`define IPP_REGS_VH

// Register byte offsets (address bits 4:2 select the word)
`define IPP_OFS_STATUS 5'h00
`define IPP_OFS_RELOAD 5'h04
`define IPP_OFS_PRIOCTL 5'h08
`define IPP_OFS_CTRL 5'h0C
`define IPP_OFS_TMRCNT 5'h10
`define IPP_OFS_TMRSTAT 5'h14

// Interrupt status fields
`define IPP_STAT_LVL_LSB 8
`define IPP_STAT_LVL_MSB 10
`define IPP_STAT_VEC_LSB 0
`define IPP_STAT_VEC_MSB 5

// Source priority control fields
`define IPP_PC_A_SUB_LSB 0
`define IPP_PC_A_SUB_MSB 1
`define IPP_PC_A_PRI_LSB 2
`define IPP_PC_A_PRI_MSB 4
`define IPP_PC_B_SUB_LSB 8
`define IPP_PC_B_SUB_MSB 9
`define IPP_PC_B_PRI_LSB 10
`define IPP_PC_B_PRI_MSB 12
`define IPP_PC_WMASK 32'h00001F1F

// Control fields
`define IPP_CTRL_THR_LSB 0
`define IPP_CTRL_THR_MSB 2
`define IPP_CTRL_SVEC_BIT 8
`define IPP_CTRL_WMASK 32'h00000107

// Timer status fields
`define IPP_TS_RUN_BIT 0
`define IPP_TS_EXP_BIT 1

// Reset values
`define IPP_RST_RELOAD 32'h00000000
`define IPP_RST_PRIOCTL 32'h00000000
`define IPP_RST_CTRL 32'h00000000

// Vector numbers presented for each source
`define IPP_VEC_SRC_A 6'h00
`define IPP_VEC_SRC_B 6'h01

`endif

// [logic/ipp_arbiter.v]
/*
 * Combinational priority selection between two interrupt sources.
 * Assumes priority and subpriority fields come straight from registers.
 */
`timescale 1ns/1ps
module ipp_arbiter (
	// Source requests
	input wire [1:0] i_req,
	// Priority fields
	input wire [2:0] i_pri_a,
	input wire [1:0] i_sub_a,
	input wire [2:0] i_pri_b,
	input wire [1:0] i_sub_b,
	// Selection
	output reg o_valid,
	output reg o_sel_b,
	output reg [2:0] o_level
);

	// Rank of a source: zero when it cannot win
	function [5:0] ipp_rank;
		input req;
		input [2:0] pri;
		input [1:0] sub;
		begin
			if (req && (pri != 3'h0)) begin
				ipp_rank = {1'b1, pri, sub};
			end else begin
				ipp_rank = 6'h00;
			end
		end
	endfunction

	reg [5:0] rank_a;
	reg [5:0] rank_b;

	always @* begin
		rank_a = ipp_rank(i_req[0], i_pri_a, i_sub_a);
		rank_b = ipp_rank(i_req[1], i_pri_b, i_sub_b);
		// Equal rank goes to source a, the lower natural order
		o_sel_b = (rank_b > rank_a);
		o_valid = rank_a[5] | rank_b[5];
		o_level = o_sel_b ? i_pri_b : i_pri_a;
	end

endmodule

// [logic/ipp_prox_timer.v]
/*
 * Interrupt proximity timer: reloads on a triggering interrupt event,
 * counts down once per enabled clock and flags expiry at zero.
 * Assumes i_trigger stays high while a deferred interrupt is pending.
 */
`timescale 1ns/1ps
module ipp_prox_timer (
	// Clock, reset and enable
	input wire i_core_clk,
	input wire i_resetn,
	input wire i_ce,
	// Control
	input wire i_trigger,
	input wire [31:0] i_reload,
	// State
	output reg [31:0] o_count,
	output wire o_running,
	output wire o_expired
);

	localparam [2:0] ST_IDLE = 3'h1;
	localparam [2:0] ST_RUN = 3'h2;
	localparam [2:0] ST_EXP = 3'h4;

	reg [2:0] state;

	assign o_running = state[1];
	assign o_expired = state[2];

	always @(posedge i_core_clk or negedge i_resetn) begin
		if (!i_resetn) begin
			state <= ST_IDLE;
			o_count <= 32'h00000000;
		end else if (i_ce) begin
			case (state)
				ST_IDLE: begin
					if (i_trigger) begin
						o_count <= i_reload;
						state <= ST_RUN;
					end
				end
				ST_RUN: begin
					// Withdrawn request cancels the wait; next event reloads afresh
					if (!i_trigger) begin
						state <= ST_IDLE;
					end else if (o_count == 32'h00000000) begin
						state <= ST_EXP;
					end else begin
						o_count <= o_count - 32'h00000001;
					end
				end
				ST_EXP: begin
					if (!i_trigger) begin
						state <= ST_IDLE;
					end
				end
				default: begin
					state <= ST_IDLE;
				end
			endcase
		end
	end

endmodule

// [test/ipp_props.sv]
/* Port checker for ipp_core.
   Assumes one clock domain; bound below. */
`timescale 1ns/1ps
module ipp_props (
	// Clock, reset, enable and bus
	input wire i_core_clk,
	input wire i_resetn,
	input wire i_ce,
	input wire i_wb_cyc,
	input wire i_wb_stb,
	input wire i_wb_we,
	input wire [4:0] i_wb_adr,
	input wire [31:0] o_wb_dat,
	input wire o_wb_ack,
	input wire o_wb_err,
	// Interrupt path
	input wire [1:0] i_src_req,
	input wire o_core_irq_req,
	input wire [2:0] o_core_irq_level,
	input wire [5:0] o_core_irq_vector
);
	default clocking @(posedge i_core_clk); endclocking
	default disable iff (!i_resetn);
	wire rd = i_wb_cyc && i_wb_stb && !i_wb_we;
	a_bus_answer: assert property (rd && !o_wb_ack && !o_wb_err && i_ce |=> o_wb_ack || o_wb_err)
		else $error("no bus answer");
	a_ack_pulse: assert property (o_wb_ack && i_ce |=> !o_wb_ack)
		else $error("ack too long");
	a_stat_zero: assert property (o_wb_ack && $past(rd && i_wb_adr[4:2] == 3'h0) |-> o_wb_dat[31:11] == 21'h0)
		else $error("status upper bits set");
	a_stat_level: assert property (o_wb_ack && $past(rd && i_wb_adr[4:2] == 3'h0) |->
		o_wb_dat[10:8] == $past(o_core_irq_level))
		else $error("status level wrong");
	a_stat_vector: assert property (o_wb_ack && $past(rd && i_wb_adr[4:2] == 3'h0) |->
		o_wb_dat[5:0] == $past(o_core_irq_vector))
		else $error("status vector wrong");
	a_pc_gap: assert property (o_wb_ack && $past(rd && i_wb_adr[4:2] == 3'h2) |-> o_wb_dat[7:5] == 3'h0)
		else $error("priority gap bits set");
	a_level_nonzero: assert property (o_core_irq_req |-> o_core_irq_level != 3'h0)
		else $error("disabled level forwarded");
	a_req_drop: assert property (i_src_req == 2'h0 && i_ce |=> !o_core_irq_req)
		else $error("request outlived source");
	a_req_cause: assert property ($rose(o_core_irq_req) |-> $past(i_src_req) != 2'h0)
		else $error("request without source");
endmodule
bind ipp_core ipp_props u_props (.i_core_clk(i_core_clk), .i_resetn(i_resetn), .i_ce(i_ce), .i_wb_cyc(i_wb_cyc),
	.i_wb_stb(i_wb_stb), .i_wb_we(i_wb_we), .i_wb_adr(i_wb_adr), .o_wb_dat(o_wb_dat), .o_wb_ack(o_wb_ack),
	.o_wb_err(o_wb_err), .i_src_req(i_src_req), .o_core_irq_req(o_core_irq_req),
	.o_core_irq_level(o_core_irq_level), .o_core_irq_vector(o_core_irq_vector));

// [test/ipp_cpu_model.sv]
/* Processor core model taking presented interrupts.
   Assumes registered request, level and vector. */
`timescale 1ns/1ps
module ipp_cpu_model (
	// Clock and reset
	input wire i_core_clk,
	input wire i_resetn,
	// Presented interrupt
	input wire i_irq_req,
	input wire [2:0] i_irq_level,
	input wire [5:0] i_irq_vector,
	// Last taken level and vector
	output reg [8:0] o_taken
);
	reg req_d;
	// Entry only on a new request, as a core starting its handler
	always @(posedge i_core_clk or negedge i_resetn) begin
		if (!i_resetn) begin
			req_d <= 1'b0;
			o_taken <= 9'h000;
		end else begin
			req_d <= i_irq_req;
			if (i_irq_req && !req_d)
				o_taken <= {i_irq_level, i_irq_vector};
		end
	end
endmodule

// [test/testbench.sv]
/* Self-checking bench for ipp_core.
   Assumes a Wishbone master and the core model. */
`timescale 1ns/1ps
module testbench;
	logic clk, rstn, ce, cyc, stb, we, ack, err, req, expd, e;
	logic [4:0] adr;
	logic [3:0] sel;
	logic [31:0] dat, rdat, q;
	logic [1:0] src;
	logic [2:0] lvl;
	logic [5:0] vec;
	logic [8:0] taken;
	int n_fail = 0;
	int check_count = 0;
	int n;
	ipp_core dut (.i_core_clk(clk), .i_resetn(rstn), .i_ce(ce), .i_wb_cyc(cyc), .i_wb_stb(stb), .i_wb_we(we),
		.i_wb_adr(adr), .i_wb_sel(sel), .i_wb_dat(dat), .o_wb_dat(rdat), .o_wb_ack(ack), .o_wb_err(err),
		.i_src_req(src), .o_core_irq_req(req), .o_core_irq_level(lvl), .o_core_irq_vector(vec),
		.o_prox_expired(expd));
	ipp_cpu_model cpu (.i_core_clk(clk), .i_resetn(rstn), .i_irq_req(req), .i_irq_level(lvl),
		.i_irq_vector(vec), .o_taken(taken));
	////////////////////////////////////////////////////////////////
	task chk(input logic [31:0] seen, input logic [31:0] exp);
		check_count++;
		if (seen !== exp) begin
			n_fail++;
			$display("CHECK FAILED t=%0t seen %h exp %h", $time, seen, exp);
		end
	endtask
	task wb(input logic w, input logic [4:0] a, input logic [31:0] d);
		@(posedge clk);
		cyc <= 1'b1;
		stb <= 1'b1;
		we <= w;
		adr <= a;
		dat <= d;
		// No cycle count is assumed here; only the watchdog ends a hung wait
		do begin
			@(posedge clk);
		end while (!(ack || err));
		q = rdat;
		e = err;
		cyc <= 1'b0;
		stb <= 1'b0;
	endtask
	task irq(input logic [1:0] s);
		n = 0;
		@(posedge clk);
		src <= s;
		do begin
			@(posedge clk);
			#1;
			n++;
		end while (!req && n < 40);
		// The core model takes the request one edge after it appears
		@(posedge clk);
		#1;
	endtask
	task drop;
		@(posedge clk);
		src <= 2'h0;
		repeat (2) @(posedge clk);
		#1;
		chk({31'h0, req}, 32'h0);
	endtask
	////////////////////////////////////////////////////////////////
	task t_regs;
		wb(0, 5'h04, 32'h0);
		chk(q, 32'h0);
		wb(1, 5'h04, 32'hA5C30F71);
		wb(0, 5'h04, 32'h0);
		chk(q, 32'hA5C30F71);
		wb(1, 5'h08, 32'hFFFFFFFF);
		wb(0, 5'h08, 32'h0);
		chk(q, 32'h00001F1F);
		wb(1, 5'h00, 32'hFFFFFFFF);
		wb(0, 5'h00, 32'h0);
		chk(q, 32'h0);
		wb(0, 5'h18, 32'h0);
		chk({31'h0, e}, 32'h1);
		$display("test regs done");
	endtask
	task t_prio;
		wb(1, 5'h0C, 32'h0);
		wb(1, 5'h08, 32'h00000E0D);
		irq(2'h3);
		chk(n, 32'h1);
		chk({23'h0, taken}, 32'h0C1);
		drop;
		wb(1, 5'h08, 32'h00001414);
		irq(2'h3);
		chk({23'h0, taken}, 32'h140);
		wb(0, 5'h00, 32'h0);
		chk(q, 32'h00000500);
		drop;
		wb(1, 5'h08, 32'h00000003);
		irq(2'h1);
		chk({31'h0, req}, 32'h0);
		drop;
		$display("test prio done");
	endtask
	task t_prox;
		wb(1, 5'h0C, 32'h3);
		wb(0, 5'h0C, 32'h0);
		chk(q, 32'h3);
		wb(1, 5'h08, 32'h8);
		for (int r = 0; r < 6; r += 5) begin
			wb(1, 5'h04, r);
			irq(2'h1);
			chk(n, r + 3);
			chk({23'h0, taken}, 32'h080);
			chk({31'h0, expd}, 32'h1);
			wb(0, 5'h14, 32'h0);
			chk(q, 32'h2);
			wb(0, 5'h10, 32'h0);
			chk(q, 32'h0);
			drop;
			chk({31'h0, expd}, 32'h0);
		end
		$display("test prox done");
	endtask
	task give_verdict;
		$display("checks %0d failures %0d", check_count, n_fail);
		if (n_fail == 0 && check_count > 0)
			$display("All checks passed");
		else
			$display("Checks failed");
		$finish;
	endtask
	////////////////////////////////////////////////////////////////
	initial begin
		clk = 1'b0;
		forever #20 clk = ~clk;
	end
	initial begin
		rstn = 1'b0;
		ce = 1'b1;
		cyc = 1'b0;
		stb = 1'b0;
		we = 1'b0;
		adr = 5'h00;
		sel = 4'hF;
		dat = 32'h0;
		src = 2'h0;
		repeat (5) @(posedge clk);
		rstn <= 1'b1;
		t_regs;
		t_prio;
		t_prox;
		give_verdict;
	end
	// Tests need well under 1000 cycles
	initial begin
		#100000;
		n_fail++;
		give_verdict;
	end
endmodule
